/* pin_sync.sv */
// Purpose: Two-stage synchroniser for asynchronous pins
// Assumes: Inputs are levels; pulses shorter than one mclk period may be lost
// Notes:   First stage is read only by the second
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rstn,
  // Pins
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      // Idle levels avoid a false edge right after reset
      stage1 <= INIT;
      synced <= INIT;
    end else begin
      stage1 <= raw;
      synced <= stage1;
    end
  end

endmodule // pin_sync

`default_nettype wire

/* testbench.sv */
// Purpose: Self-checking bench for the display controller
// Assumes: Small prescale so key frames are short
// Notes:   Results go through a queue of notes to one monitor
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct {logic [31:0] val; logic [31:0] mask; bit link;} note_type;
  localparam logic [31:0] SMASK = 32'h0007_fef7;
  logic mclk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, got, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  keys = 4'h0, sw = 4'h0, litN;
  logic frameSel, shClk, serIn, outEn, serOut;
  logic [1:0]  resp;
  logic [15:0] seg;
  logic [10:0] grid;
  logic [5:0]  keySrc;
  wire logic dataLine;
  logic [7:0]  d;
  note_type    notes[$];
  note_type    e;
  int n_mismatch = 0, checks = 0;
  event gotEv;
  // Pull-up holds the line high whenever the open drain lets go
  assign dataLine = outEn ? serOut : 1'b1;
  always #10 mclk = ~mclk;
  vfd_controller #(.PRESCALE(4)) DUT (.mclk(mclk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(resp),
    .frameSelect(frameSel), .shiftClock(shClk), .serialIn(serIn), .serialOut(serOut),
    .serialOutEn(outEn), .segmentOutputs(seg), .gridOutputs(grid), .keySourceLines(keySrc),
    .keyReturnLines(keys), .switchInputs(sw), .indicatorLitN(litN));
  vfd_host_model host (.frameSelect(frameSel), .shiftClock(shClk), .serialIn(serIn),
    .dataLine(dataLine));
  // ----------------------------------------------------------------
  // Bus, link and compare tasks
  // ----------------------------------------------------------------
  task automatic ahbXfer(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic busCheck(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    notes.push_back('{v, m, 1'b0});
    ahbXfer(a, 1'b0, 32'h0);
    // Any response but OKAY disturbs the word and shows as a mismatch
    got = rd ^ {30'h0, resp};
    ->gotEv;
  endtask
  // Segments and key sources seen while the last grid is lit
  task automatic gridCheck(input logic [15:0] v);
    notes.push_back('{{16'h0, v}, 32'h003f_ffff, 1'b0});
    do @(negedge mclk); while (grid !== 11'h400);
    got = {10'h0, keySrc, seg};
    ->gotEv;
  endtask
  task automatic linkCheck(input logic [7:0] v);
    logic [7:0] b;
    notes.push_back('{{24'h0, v}, 32'hff, 1'b1});
    host.readByte(b);
    got = {24'h0, b};
    ->gotEv;
  endtask
  task automatic frame(input logic [7:0] c, input int n, input logic [7:0] b);
    host.strobe(1'b0);
    host.sendBits(c, 8);
    for (int i = 0; i < n; i++) host.sendBits(b + 8'(i), 8);
    host.strobe(1'b1);
  endtask
  function automatic logic [31:0] stat(logic [2:0] md, logic on, logic [2:0] dm,
                                       logic [4:0] ad, logic [2:0] st);
    return {13'h0, st, 2'h0, ad, 1'b0, on, dm, 1'b0, md};
  endfunction
  task automatic compareWord(input logic [31:0] x, input logic [31:0] y);
    checks++;
    if (x !== y) begin
      n_mismatch++;
      $display("ERROR bus word expected %h seen %h", x, y);
    end
  endtask
  task automatic compareByte(input logic [7:0] x, input logic [7:0] y);
    checks++;
    if (x !== y) begin
      n_mismatch++;
      $display("ERROR link byte expected %h seen %h", x, y);
    end
  endtask
  task automatic results;
    n_mismatch += notes.size();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(gotEv) begin
    e = notes.pop_front();
    if (e.link) compareByte(e.val[7:0], got[7:0]);
    else compareWord(e.val, got & e.mask);
  end
  // Whole run needs about 7000 cycles
  initial begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    results();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(88298));
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    keys <= 4'($urandom) | 4'h1;
    sw   <= 4'($urandom);
    d    = 8'($urandom);
    busCheck(vfd_pkg::OFS_STATUS, stat(3'h7, 1'b0, 3'h0, 5'h0, 3'h0), SMASK);
    busCheck(vfd_pkg::OFS_PORTS, {24'h0, sw, 4'hf}, 32'hff);
    busCheck(vfd_pkg::OFS_CTRL, vfd_pkg::CTRL_RESET, '1);
    busCheck(8'h40, 32'h0, '1);
    repeat (1600) @(posedge mclk);
    busCheck(vfd_pkg::OFS_KEYS, 32'h0, '1);
    frame(8'h41, 1, d);
    busCheck(vfd_pkg::OFS_PORTS, {24'h0, sw, d[3:0]}, 32'hff);
    host.strobe(1'b0);
    host.sendBits(8'h41, 8);
    host.sendBits(~d, 4);
    host.strobe(1'b1);
    host.noise(8);
    busCheck(vfd_pkg::OFS_PORTS, {24'h0, sw, d[3:0]}, 32'hff);
    ahbXfer(vfd_pkg::OFS_CTRL, 1'b1, 32'h0);
    frame(8'h41, 1, ~d);
    busCheck(vfd_pkg::OFS_PORTS, {24'h0, sw, d[3:0]}, 32'hff);
    ahbXfer(vfd_pkg::OFS_CTRL, 1'b1, 32'h1);
    frame(8'h40, 0, d);
    frame(8'hc5, 3, d);
    busCheck(vfd_pkg::OFS_STATUS, stat(3'h7, 1'b0, 3'h0, 5'h8, 3'h0), SMASK);
    frame(8'hd4, 3, d);
    busCheck(vfd_pkg::OFS_STATUS, stat(3'h7, 1'b0, 3'h0, 5'h16, 3'h0), SMASK);
    frame(8'h44, 0, d);
    frame(8'hc3, 2, d);
    busCheck(vfd_pkg::OFS_STATUS, stat(3'h7, 1'b0, 3'h0, 5'h3, 3'h4), SMASK);
    frame(8'h40, 0, d);
    frame(8'h8f, 0, d);
    frame(8'h07, 0, d);
    busCheck(vfd_pkg::OFS_STATUS, stat(3'h7, 1'b1, 3'h7, 5'h3, 3'h0), SMASK);
    gridCheck({d + 8'h1, d} & 16'h07ff);
    repeat (2000) @(posedge mclk);
    busCheck(vfd_pkg::OFS_KEYS, {8'h0, {6{keys}}}, '1);
    host.strobe(1'b0);
    host.sendBits(8'h42, 8);
    for (int i = 0; i < 3; i++) linkCheck({keys, keys});
    host.strobe(1'b1);
    host.strobe(1'b0);
    host.sendBits(8'h43, 8);
    linkCheck({4'h0, sw});
    linkCheck(8'hff);
    host.strobe(1'b1);
    frame(8'h03, 0, d);
    busCheck(vfd_pkg::OFS_STATUS, stat(3'h3, 1'b0, 3'h0, 5'h0, 3'h0), 32'h87);
    // Let the monitor take the last note before the verdict
    repeat (2) @(posedge mclk);
    results();
  end
endmodule // testbench
`default_nettype wire

/* vfd_controller.sv */
// Purpose: Serially commanded display controller with key scan and LED port
// Assumes: Shift clock well below mclk/4; one AHB-Lite slave with zero wait states
// Notes:   Display timing is derived from mclk instead of a separate oscillator
`timescale 1ns/10ps
`default_nettype none

module vfd_controller #(
  parameter int PRESCALE = 64
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic [1:0]       hresp,
  // Serial link
  input  wire logic        frameSelect,
  input  wire logic        shiftClock,
  input  wire logic        serialIn,
  output logic             serialOut,
  output logic             serialOutEn,
  // Panel
  output logic [15:0]      segmentOutputs,
  output logic [10:0]      gridOutputs,
  output logic [5:0]       keySourceLines,
  input  wire logic [3:0]  keyReturnLines,
  input  wire logic [3:0]  switchInputs,
  output logic [3:0]       indicatorLitN
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [vfd_pkg::SYNC_WIDTH-1:0] syncOut;
  logic                           stbS;
  logic                           clkS;
  logic                           dinS;
  logic [3:0]                     keyS;
  logic [3:0]                     swS;
  logic                           prevClk;
  logic                           prevStb;

  pin_sync #(.WIDTH(vfd_pkg::SYNC_WIDTH), .INIT(vfd_pkg::SYNC_RESET)) u_sync (
    .mclk   (mclk),
    .rstn   (rstn),
    .raw    ({switchInputs, keyReturnLines, serialIn, shiftClock, frameSelect}),
    .synced (syncOut)
  );

  assign stbS = syncOut[0];
  assign clkS = syncOut[1];
  assign dinS = syncOut[2];
  assign keyS = syncOut[6:3];
  assign swS  = syncOut[10:7];

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      prevClk <= 1'b1;
      prevStb <= 1'b1;
    end else begin
      prevClk <= clkS;
      prevStb <= stbS;
    end
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [31:0] ctrlReg;
  logic        wrPending;
  logic [7:0]  wrOffset;
  logic        linkEnable;
  logic        addrPhase;

  assign linkEnable = ctrlReg[0];
  assign addrPhase  = hsel & hready & htrans[1];
  assign hreadyout  = 1'b1;
  assign hresp      = vfd_pkg::HRESP_OKAY;

  // Receiver state declared early for the status view
  logic [2:0]           bitCount;
  logic [7:0]           shiftReg;
  logic                 expectCmd;
  logic [2:0]           mode;
  vfd_pkg::control_type control;
  vfd_pkg::setting_type setting;
  logic [4:0]           addr;
  logic [23:0]          keyData;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wrPending <= 1'b0;
      wrOffset  <= vfd_pkg::OFS_CTRL;
    end else begin
      wrPending <= addrPhase & hwrite;
      wrOffset  <= haddr[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctrlReg <= vfd_pkg::CTRL_RESET;
    end else if (wrPending && wrOffset == vfd_pkg::OFS_CTRL) begin
      ctrlReg <= {31'h0000_0000, hwdata[0]};
    end
  end

  // Read data registered in the address phase; unmapped offsets read zero
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      case (haddr[7:0])
        vfd_pkg::OFS_CTRL:   hrdata <= ctrlReg;
        vfd_pkg::OFS_STATUS: hrdata <= {13'h0000, setting, 2'h0, addr, 1'b0,
                                        control, expectCmd, mode};
        vfd_pkg::OFS_PORTS:  hrdata <= {24'h00_0000, swS, indicatorLitN};
        vfd_pkg::OFS_KEYS:   hrdata <= {8'h00, keyData};
        default:             hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Serial receiver
  // ----------------------------------------------------------------
  logic       linkIdle;
  logic       clkRise;
  logic       clkFall;
  logic       byteDone;
  logic [7:0] byteValue;
  logic       cmdDone;
  logic       dataDone;

  assign linkIdle  = stbS | ~linkEnable;
  assign clkRise   = ~linkIdle & clkS & ~prevClk;
  assign clkFall   = ~linkIdle & ~clkS & prevClk;
  assign byteValue = {dinS, shiftReg[7:1]};
  assign byteDone  = clkRise && bitCount == vfd_pkg::LAST_BIT;
  assign cmdDone   = byteDone & expectCmd;
  assign dataDone  = byteDone & ~expectCmd;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      bitCount  <= 3'h0;
      shiftReg  <= 8'h00;
      expectCmd <= 1'b1;
    end else if (linkIdle) begin
      bitCount  <= 3'h0;
      expectCmd <= 1'b1;
    end else if (clkRise) begin
      shiftReg <= byteValue;
      bitCount <= bitCount + 3'h1;
      if (bitCount == vfd_pkg::LAST_BIT) begin
        expectCmd <= 1'b0;
      end
    end
  end

  a_partial_discard: assert property (@(posedge mclk) disable iff (!rstn)
    stbS |=> bitCount == 3'h0 && !byteDone) else $error("partial byte kept");
  a_first_command: assert property (@(posedge mclk) disable iff (!rstn)
    !stbS && prevStb |-> expectCmd) else $error("frame not armed for command");

  // ----------------------------------------------------------------
  // Command execution
  // ----------------------------------------------------------------
  logic [1:0]  cmdClass;
  logic        modeCmd;
  logic        modeChange;
  logic        dispWrite;
  logic [7:0]  ram [vfd_pkg::RAM_DEPTH];

  assign cmdClass   = byteValue[7:6];
  assign modeCmd    = cmdDone && cmdClass == vfd_pkg::CLASS_MODE;
  assign modeChange = modeCmd && byteValue[2:0] != mode;
  assign dispWrite  = dataDone && setting.xfer == vfd_pkg::XFER_DISPLAY
                      && addr < vfd_pkg::ADDR_LIMIT;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mode <= vfd_pkg::MODE_RESET;
    end else if (modeChange) begin
      mode <= byteValue[2:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      control <= vfd_pkg::CONTROL_RESET;
    end else if (modeChange) begin
      control.on <= 1'b0;
    end else if (cmdDone && cmdClass == vfd_pkg::CLASS_CONTROL) begin
      control <= byteValue[3:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      setting <= vfd_pkg::SETTING_RESET;
    end else if (cmdDone && cmdClass == vfd_pkg::CLASS_SETTING) begin
      setting <= byteValue[2:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      addr <= vfd_pkg::ADDR_RESET;
    end else if (cmdDone && cmdClass == vfd_pkg::CLASS_ADDRESS) begin
      addr <= byteValue[4:0];
    end else if (dispWrite && !setting.fixedAddr) begin
      addr <= addr + 5'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (dispWrite) begin
      ram[addr] <= byteValue;
    end
  end

  // Only the low nibble reaches the pins; bits 4 to 7 are dropped
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      indicatorLitN <= vfd_pkg::LED_UNLIT;
    end else if (dataDone && setting.xfer == vfd_pkg::XFER_LED) begin
      indicatorLitN <= byteValue[3:0];
    end
  end

  a_mode_change_off: assert property (@(posedge mclk) disable iff (!rstn)
    modeChange |=> !control.on ##1 !control.on || $past(cmdDone)) else $error("mode change left display on");
  a_same_mode_keep: assert property (@(posedge mclk) disable iff (!rstn)
    modeCmd && byteValue[2:0] == mode |=> $stable(control) && $stable(mode)) else $error("same mode disturbed state");
  a_addr_ignore: assert property (@(posedge mclk) disable iff (!rstn)
    dataDone && addr >= vfd_pkg::ADDR_LIMIT |=> $stable(addr)) else $error("data used past address limit");
  a_addr_incr: assert property (@(posedge mclk) disable iff (!rstn)
    dispWrite && !setting.fixedAddr |=> addr == $past(addr) + 5'h01) else $error("address did not advance");
  a_led_write: assert property (@(posedge mclk) disable iff (!rstn)
    dataDone && setting.xfer == vfd_pkg::XFER_LED |=> indicatorLitN == $past(byteValue[3:0])) else $error("led port not written");
  a_reset_defaults: assert property (@(posedge mclk)
    rstn && !$past(rstn) |-> mode == vfd_pkg::MODE_RESET && !control.on && addr == 5'h00
    && indicatorLitN == vfd_pkg::LED_UNLIT && !setting.fixedAddr) else $error("bad power-up state");

  // ----------------------------------------------------------------
  // Read transmitter
  // ----------------------------------------------------------------
  logic       readActive;
  logic [1:0] readByte;
  logic [2:0] readBit;
  logic [7:0] txByte;
  logic       keyRead;

  always_comb begin
    txByte = vfd_pkg::IDLE_BYTE;
    if (keyRead && readByte < vfd_pkg::KEY_BYTES) begin
      txByte = keyData[{readByte, 3'h0} +: 8];
    end else if (!keyRead && readByte < vfd_pkg::SW_BYTES) begin
      txByte = {4'h0, swS};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      readActive <= 1'b0;
      keyRead    <= 1'b0;
    end else if (linkIdle) begin
      readActive <= 1'b0;
    end else if (cmdDone) begin
      readActive <= cmdClass == vfd_pkg::CLASS_SETTING && byteValue[1];
      keyRead    <= byteValue[1:0] == vfd_pkg::XFER_KEY;
    end
  end

  // Open drain: enable only while pulling low, released between frames
  always_ff @(posedge mclk) begin
    if (!rstn || linkIdle || cmdDone) begin
      readByte    <= 2'h0;
      readBit     <= 3'h0;
      serialOutEn <= 1'b0;
    end else if (readActive && clkFall) begin
      serialOutEn <= ~txByte[readBit];
      readBit     <= readBit + 3'h1;
      if (readBit == vfd_pkg::LAST_BIT && readByte != vfd_pkg::KEY_BYTES) begin
        readByte <= readByte + 2'h1;
      end
    end
  end

  assign serialOut = 1'b0;

  a_dout_release: assert property (@(posedge mclk) disable iff (!rstn)
    stbS |=> !serialOutEn) else $error("data out driven while idle");

  // ----------------------------------------------------------------
  // Display multiplex and key scan
  // ----------------------------------------------------------------
  logic [$clog2(PRESCALE)-1:0] preCount;
  logic                        tick;
  logic [3:0]                  sixteenth;
  logic [3:0]                  slot;
  logic [3:0]                  gridCount;
  logic                        keySlot;
  logic [2:0]                  srcIdx;
  logic [23:0]                 keyRaw;
  logic                        frameEnd;

  assign tick      = preCount == ($clog2(PRESCALE))'(PRESCALE - 1);
  assign gridCount = vfd_pkg::GRID_BASE + {1'b0, mode};
  assign keySlot   = slot == gridCount;
  assign srcIdx    = sixteenth[3:1];
  assign frameEnd  = tick && keySlot && sixteenth == 4'hf;

  // Slot after the last grid is spent on the key matrix
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      preCount  <= '0;
      sixteenth <= 4'h0;
      slot      <= 4'h0;
    end else begin
      preCount <= tick ? '0 : preCount + 1'b1;
      if (tick) begin
        sixteenth <= sixteenth + 4'h1;
        if (sixteenth == 4'hf) begin
          slot <= (slot >= gridCount) ? 4'h0 : slot + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      keyRaw  <= 24'h00_0000;
      keyData <= 24'h00_0000;
    end else if (control.on) begin
      if (tick && keySlot && sixteenth[0] && srcIdx < vfd_pkg::KEY_SOURCES) begin
        keyRaw[{srcIdx, 2'h0} +: 4] <= keyS;
      end
      if (frameEnd) begin
        keyData <= keyRaw;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      keySourceLines <= 6'h00;
      gridOutputs    <= 11'h000;
      segmentOutputs <= 16'h0000;
    end else begin
      keySourceLines <= 6'h00;
      gridOutputs    <= 11'h000;
      segmentOutputs <= 16'h0000;
      if (control.on && keySlot && srcIdx < vfd_pkg::KEY_SOURCES) begin
        keySourceLines <= 6'h01 << srcIdx;
      end
      if (control.on && !keySlot && slot < gridCount
          && {1'b0, sixteenth} < vfd_pkg::dimWidth(control.dim)) begin
        gridOutputs    <= 11'h001 << slot;
        segmentOutputs <= {ram[{slot, 1'b1}], ram[{slot, 1'b0}]}
                          & vfd_pkg::segMask(mode);
      end
    end
  end

  a_keyscan_off: assert property (@(posedge mclk) disable iff (!rstn)
    !control.on |=> keySourceLines == 6'h00 && gridOutputs == 11'h000) else $error("scan while display off");
  a_key_latch: assert property (@(posedge mclk) disable iff (!rstn)
    frameEnd && control.on |=> keyData == $past(keyRaw)) else $error("key data not latched");

endmodule // vfd_controller

`default_nettype wire

/* vfd_host_model.sv */
// Purpose: Host model driving the three-wire display link
// Assumes: 160 ns shift clock idling high, data line pulled up
// Notes:   Tasks are called by the testbench
`timescale 1ns/10ps
`default_nettype none
module vfd_host_model (
  // Link
  output logic      frameSelect,
  output logic      shiftClock,
  output logic      serialIn,
  input  wire logic dataLine
);
  initial begin
    frameSelect = 1'b1;
    shiftClock  = 1'b1;
    serialIn    = 1'b0;
  end
  task automatic sendBits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      shiftClock = 1'b0;
      serialIn   = b[i];
      #80;
      shiftClock = 1'b1;
      #80;
    end
  endtask
  task automatic readByte(output logic [7:0] b);
    #1000;
    for (int i = 0; i < 8; i++) begin
      shiftClock = 1'b0;
      #80;
      shiftClock = 1'b1;
      b[i]       = dataLine;
      #80;
    end
  endtask
  // Odd offset keeps strobe edges off the mclk grid
  task automatic strobe(input logic level);
    #87;
    frameSelect = level;
    serialIn    = ~serialIn;
    #160;
  endtask
  // Clock edges while the strobe is high
  task automatic noise(input int n);
    for (int i = 0; i < n; i++) begin
      shiftClock = 1'b0;
      serialIn   = 1'($urandom);
      #80;
      shiftClock = 1'b1;
      #80;
    end
  endtask
endmodule // vfd_host_model
`default_nettype wire

/* vfd_pkg.sv */
// Purpose: Shared constants and types for the serially commanded display controller
// Assumes: 50 MHz mclk, AHB-Lite status and control port, host-driven shift clock
// Notes:   Functional notes below list the behaviour of the design files
//
// Functional notes
// - Display RAM holds bytes 00H to 15H.
// - First byte after strobe falls is command.
// - Strobe rise mid-byte drops that byte only.
// - Mode command picks segment and grid counts.
// - Mode change blanks display, halts key scan.
// - Same mode command changes nothing.
// - Power-up mode is eleven digits, eleven segments.
// - Data setting picks transfer; default write, increment.
// - Address 16H or above ignores data bytes.
// - Address pointer resets to zero.
// - Power-up: narrowest dimming, display off.
// - Key scan idle until display enabled.
// - Six by four keys sampled each frame.
// - Key read shifts stored data LSB first.
// - LED write LSB first, 0 lights LED.
// - All LEDs unlit after power-up.
// - Switch read LSB first, upper bits zero.
// - Input sampled on rising clock, LSB first.
// - Read bit driven on falling edge, open drain.
// - Strobe high: shift clock ignored.
// - Key returns latched at each frame end.

package vfd_pkg;

  // ----------------------------------------------------------------
  // Memory and command layout
  // ----------------------------------------------------------------
  localparam int          RAM_DEPTH     = 22;
  localparam logic [4:0]  ADDR_LIMIT    = 5'h16;
  localparam logic [4:0]  ADDR_RESET    = 5'h00;
  localparam logic [2:0]  LAST_BIT      = 3'h7;
  localparam logic [1:0]  CLASS_MODE    = 2'h0;
  localparam logic [1:0]  CLASS_SETTING = 2'h1;
  localparam logic [1:0]  CLASS_CONTROL = 2'h2;
  localparam logic [1:0]  CLASS_ADDRESS = 2'h3;
  localparam logic [2:0]  MODE_RESET    = 3'h7;
  localparam logic [3:0]  GRID_BASE     = 4'h4;
  localparam logic [2:0]  DIM_RESET     = 3'h0;
  localparam logic [3:0]  LED_UNLIT     = 4'hf;
  localparam logic [2:0]  KEY_SOURCES   = 3'h6;
  localparam logic [1:0]  KEY_BYTES     = 2'h3;
  localparam logic [1:0]  SW_BYTES      = 2'h1;
  localparam logic [7:0]  IDLE_BYTE     = 8'hff;
  localparam int          SYNC_WIDTH    = 11;
  // Strobe and shift clock idle high, so the synchroniser starts there
  localparam logic [10:0] SYNC_RESET    = 11'h003;

  typedef enum logic [1:0] {
    XFER_DISPLAY = 2'b00,
    XFER_LED     = 2'b01,
    XFER_KEY     = 2'b10,
    XFER_SWITCH  = 2'b11
  } xfer_type;

  typedef struct packed {
    logic     fixedAddr;
    xfer_type xfer;
  } setting_type;

  typedef struct packed {
    logic       on;
    logic [2:0] dim;
  } control_type;

  localparam setting_type SETTING_RESET = '{fixedAddr: 1'b0, xfer: XFER_DISPLAY};
  localparam control_type CONTROL_RESET = '{on: 1'b0, dim: DIM_RESET};

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_PORTS     = 8'h08;
  localparam logic [7:0]  OFS_KEYS      = 8'h0c;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
  localparam logic [1:0]  HRESP_OKAY    = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLOCK_NS      = 20;
  localparam int          READ_WAIT_NS  = 1000;
  localparam int          READ_WAIT_CYC = (READ_WAIT_NS + CLOCK_NS - 1) / CLOCK_NS;

  // Pulse width in sixteenths of a grid slot
  function automatic logic [4:0] dimWidth(input logic [2:0] dim);
    case (dim)
      3'h0: dimWidth = 5'h01;
      3'h1: dimWidth = 5'h02;
      3'h2: dimWidth = 5'h04;
      3'h3: dimWidth = 5'h0a;
      3'h4: dimWidth = 5'h0b;
      3'h5: dimWidth = 5'h0c;
      3'h6: dimWidth = 5'h0d;
      default: dimWidth = 5'h0e;
    endcase
  endfunction

  // Modes 0..2 use all sixteen segments, later ones give pins to grids
  function automatic logic [15:0] segMask(input logic [2:0] mode);
    case (mode)
      3'h3: segMask = 16'h7fff;
      3'h4: segMask = 16'h3fff;
      3'h5: segMask = 16'h1fff;
      3'h6: segMask = 16'h0fff;
      3'h7: segMask = 16'h07ff;
      default: segMask = 16'hffff;
    endcase
  endfunction

endpackage
